/* File: src/dcpwm_pkg.sv */
// dcpwm_pkg: constants and carrier types for the down counter pwm timer.
// assumes an apb slave with 32-bit data and word-aligned registers.
`default_nettype none
package dcpwm_pkg;
   // register byte addresses (printed offsets are not all multiples of 4: index * 4)
   localparam logic [7:0] IDX_COUNT_LOW = 8'h09;
   localparam logic [7:0] IDX_CTRL_ONE = 8'h0a;
   localparam logic [7:0] IDX_CTRL_TWO = 8'h0b;
   localparam logic [7:0] IDX_DUTY = 8'h0c;
   localparam logic [7:0] IDX_PRESC_CNT = 8'h0d;
   localparam logic [7:0] IDX_HIGH_BITS = 8'h0e;
   localparam logic [7:0] IDX_STATUS = 8'h10;
   localparam logic [11:0] ADDR_COUNT_LOW = {2'h0, IDX_COUNT_LOW, 2'h0};
   localparam logic [11:0] ADDR_CTRL_ONE = {2'h0, IDX_CTRL_ONE, 2'h0};
   localparam logic [11:0] ADDR_CTRL_TWO = {2'h0, IDX_CTRL_TWO, 2'h0};
   localparam logic [11:0] ADDR_DUTY = {2'h0, IDX_DUTY, 2'h0};
   localparam logic [11:0] ADDR_PRESC_CNT = {2'h0, IDX_PRESC_CNT, 2'h0};
   localparam logic [11:0] ADDR_HIGH_BITS = {2'h0, IDX_HIGH_BITS, 2'h0};
   localparam logic [11:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
   // control one bit positions
   localparam int POS_RUN = 0;
   localparam int POS_RELOAD = 1;
   localparam int POS_ONE_SHOT = 2;
   localparam int POS_ACT_LOW = 6;
   localparam int POS_PIN_EN = 7;
   // control two bit positions
   localparam int POS_RATIO = 0;
   localparam int POS_PS_DIS_N = 3;
   localparam int POS_EDGE = 4;
   localparam int POS_SRC = 5;
   // high bits register positions
   localparam int POS_HI_RELOAD = 6;
   localparam int POS_HI_DUTY = 2;
   // reset values, then count limits and divider constants
   localparam logic [7:0] RST_CTRL_ONE = 8'h00;
   localparam logic [7:0] RST_CTRL_TWO = 8'h3f;
   localparam logic [7:0] RST_PRESC = 8'hff;
   localparam logic [9:0] RST_COUNT = 10'h3ff;
   localparam logic [9:0] FULL_COUNT = 10'h3ff;
   localparam logic [9:0] ZERO_COUNT = 10'h000;
   localparam logic [1:0] INSTR_DIV = 2'h3;
   localparam logic [7:0] HOLD_STRETCH = 8'h00;

   typedef struct packed {
      logic pin_en;
      logic act_low;
      logic one_shot;
      logic reload;
      logic run;
   } dcpwm_ctrl_one_s;

   typedef struct packed {
      logic src_ext;
      logic edge_fall;
      logic ps_dis_n;
      logic [2:0] ratio;
   } dcpwm_ctrl_two_s;
endpackage
`default_nettype wire

/* File: src/dcpwm_prescaler.sv */
// dcpwm_prescaler: 8-stage prescaler, free counter with ratio tap.
// assumes tick_in is a one-cycle pulse on mclk_in.
`default_nettype none
module dcpwm_prescaler (
   // clock and reset
   input wire logic mclk_in,
   input wire logic rstn_in,
   // control
   input wire logic tick_in,
   input wire logic bypass_in,
   input wire logic [2:0] ratio_in,
   // results
   output logic tick_out,
   output logic [7:0] count_out
);
   logic [7:0] cnt_ff;
   logic [7:0] nxt_cnt;
   logic [7:0] mask;
   logic tap_hit;

   // down counter; ratio 2^(sel+1) from low bits reaching zero
   assign nxt_cnt = cnt_ff - 8'h01;
   // low select+1 bits set: code 0 gives 8'h01, code 7 gives 8'hff
   assign mask = 8'((9'h002 << ratio_in) - 9'h001);
   assign tap_hit = ((cnt_ff & mask) == 8'h00);
   // bypass passes each source tick straight through
   assign tick_out = bypass_in ? tick_in : (tick_in & tap_hit);
   assign count_out = cnt_ff;

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         cnt_ff <= dcpwm_pkg::RST_PRESC;
      end else if (bypass_in) begin
         cnt_ff <= dcpwm_pkg::RST_PRESC;
      end else if (tick_in) begin
         cnt_ff <= nxt_cnt;
      end
   end
endmodule
`default_nettype wire

/* File: src/dcpwm_timer.sv */
// dcpwm_timer: 10-bit down counter, prescaler, pwm and apb registers.
// assumes an apb master on mclk_in and an asynchronous external count pin.
//
// Our own choice: the APB register port.
`default_nettype none
module dcpwm_timer (
   // clock and reset
   input wire logic mclk_in,
   input wire logic rstn_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // pins
   input wire logic external_count_pin_in,
   input wire logic gpio_out_in,
   input wire logic gpio_oe_in,
   output logic pwm_port_pin_out,
   output logic pwm_port_pin_oe_out,
   // events
   output logic underflow_event_out
);
   dcpwm_pkg::dcpwm_ctrl_one_s ctrl_one_ff;
   dcpwm_pkg::dcpwm_ctrl_two_s ctrl_two_ff;
   logic [7:0] reload_low_ff;
   logic [7:0] high_bits_ff;
   logic [7:0] duty_ff;
   logic [9:0] count_ff;
   logic [9:0] nxt_count;
   logic stopped_ff;
   logic nxt_stopped;
   logic flag_ff;
   logic [1:0] instr_div_ff;
   logic ext_sync1_ff;
   logic ext_sync2_ff;
   logic ext_prev_ff;
   logic [9:0] pwm_phase_ff;
   logic pwm_level_ff;
   logic [31:0] rdata_ff;
   logic ready_ff;
   logic slverr_ff;
   logic pin_ff;
   logic pin_oe_ff;
   logic event_ff;

   // bus decode
   logic setup;
   logic wr_en;
   logic rd_en;
   logic hit_count;
   logic hit_one;
   logic hit_two;
   logic hit_duty;
   logic hit_presc;
   logic hit_high;
   logic hit_status;
   logic mapped;
   logic [7:0] wbyte;
   logic [7:0] rbyte;

   // counting sources
   logic instr_tick;
   logic ext_rise;
   logic ext_fall;
   logic ext_tick;
   logic src_tick;
   logic count_tick;
   logic [7:0] presc_count;
   logic underflow;
   logic [9:0] reload_val;
   logic [9:0] duty_val;
   logic pwm_active;
   logic pwm_pin;
   logic status_clear;

   // zero-wait-state apb: answer on the cycle after setup
   assign setup = psel_in & ~penable_in;
   assign wr_en = psel_in & penable_in & ready_ff & pwrite_in;
   assign rd_en = setup & ~pwrite_in;
   assign hit_count = (paddr_in == dcpwm_pkg::ADDR_COUNT_LOW);
   assign hit_one = (paddr_in == dcpwm_pkg::ADDR_CTRL_ONE);
   assign hit_two = (paddr_in == dcpwm_pkg::ADDR_CTRL_TWO);
   assign hit_duty = (paddr_in == dcpwm_pkg::ADDR_DUTY);
   assign hit_presc = (paddr_in == dcpwm_pkg::ADDR_PRESC_CNT);
   assign hit_high = (paddr_in == dcpwm_pkg::ADDR_HIGH_BITS);
   assign hit_status = (paddr_in == dcpwm_pkg::ADDR_STATUS);
   assign mapped = hit_count | hit_one | hit_two | hit_duty | hit_presc | hit_high | hit_status;
   assign wbyte = pwdata_in[7:0];

   // duty register is write-only and reads as zero
   assign rbyte = hit_count ? count_ff[7:0] :
                  hit_one ? {ctrl_one_ff.pin_en, ctrl_one_ff.act_low, 3'h0,
                             ctrl_one_ff.one_shot, ctrl_one_ff.reload, ctrl_one_ff.run} :
                  hit_two ? {2'h0, ctrl_two_ff} :
                  hit_presc ? presc_count :
                  hit_high ? high_bits_ff :
                  hit_status ? {7'h00, flag_ff} : 8'h00;

   // instruction clock: system clock divided by four
   assign instr_tick = (instr_div_ff == dcpwm_pkg::INSTR_DIV);
   assign ext_rise = ext_sync2_ff & ~ext_prev_ff;
   assign ext_fall = ~ext_sync2_ff & ext_prev_ff;
   assign ext_tick = ctrl_two_ff.edge_fall ? ext_fall : ext_rise;
   assign src_tick = ctrl_two_ff.src_ext ? ext_tick : instr_tick;

   dcpwm_prescaler u_presc (
      .mclk_in(mclk_in),
      .rstn_in(rstn_in),
      .tick_in(src_tick),
      .bypass_in(ctrl_two_ff.ps_dis_n),
      .ratio_in(ctrl_two_ff.ratio),
      .tick_out(count_tick),
      .count_out(presc_count)
   );

   assign reload_val = {high_bits_ff[dcpwm_pkg::POS_HI_RELOAD +: 2], reload_low_ff};
   assign duty_val = {high_bits_ff[dcpwm_pkg::POS_HI_DUTY +: 2], duty_ff};
   // underflow: a tick while the counter is at zero and not stopped
   assign underflow = ctrl_one_ff.run & count_tick & ~stopped_ff &
                      (count_ff == dcpwm_pkg::ZERO_COUNT);

   always_comb begin
      nxt_count = count_ff;
      nxt_stopped = stopped_ff;
      if (wr_en && hit_count) begin
         nxt_count = {high_bits_ff[dcpwm_pkg::POS_HI_RELOAD +: 2], wbyte};
         nxt_stopped = 1'b0;
      end else if (ctrl_one_ff.run && count_tick && !stopped_ff) begin
         if (count_ff != dcpwm_pkg::ZERO_COUNT) begin
            nxt_count = count_ff - 10'h001;
         end else if (ctrl_one_ff.one_shot) begin
            nxt_stopped = 1'b1;
         end else if (ctrl_one_ff.reload) begin
            nxt_count = reload_val;
         end else begin
            nxt_count = dcpwm_pkg::FULL_COUNT;
         end
      end
   end

   // pwm: active from frame start until the duty count is reached
   assign pwm_active = (pwm_phase_ff < duty_val);
   assign pwm_pin = pwm_active ^ ctrl_one_ff.act_low;
   // status cleared by writing 1 to bit 0
   assign status_clear = wr_en & hit_status & wbyte[0];

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         ctrl_one_ff <= {dcpwm_pkg::RST_CTRL_ONE[7:6], dcpwm_pkg::RST_CTRL_ONE[2:0]};
         ctrl_two_ff <= dcpwm_pkg::RST_CTRL_TWO[5:0];
         reload_low_ff <= 8'h00;
         high_bits_ff <= 8'h00;
         duty_ff <= 8'h00;
      end else if (wr_en) begin
         if (hit_count) begin
            reload_low_ff <= wbyte;
         end
         if (hit_one) begin
            ctrl_one_ff <= {wbyte[dcpwm_pkg::POS_PIN_EN], wbyte[dcpwm_pkg::POS_ACT_LOW],
                            wbyte[dcpwm_pkg::POS_ONE_SHOT], wbyte[dcpwm_pkg::POS_RELOAD],
                            wbyte[dcpwm_pkg::POS_RUN]};
         end
         if (hit_two) begin
            // ratio should only change with prescaler disabled; not enforced
            ctrl_two_ff <= wbyte[5:0];
         end
         if (hit_duty) begin
            duty_ff <= wbyte;
         end
         if (hit_high) begin
            high_bits_ff <= wbyte;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         count_ff <= dcpwm_pkg::RST_COUNT;
         stopped_ff <= 1'b0;
         flag_ff <= 1'b0;
         event_ff <= 1'b0;
      end else begin
         count_ff <= nxt_count;
         stopped_ff <= nxt_stopped;
         // set wins over clear
         flag_ff <= underflow | (flag_ff & ~status_clear);
         event_ff <= underflow;
      end
   end

   // frame phase counts counter ticks from the last reload, period = reload ticks
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         pwm_phase_ff <= dcpwm_pkg::ZERO_COUNT;
         pwm_level_ff <= 1'b0;
      end else begin
         if (underflow || (pwm_phase_ff >= reload_val)) begin
            pwm_phase_ff <= dcpwm_pkg::ZERO_COUNT;
         end else if (ctrl_one_ff.run && count_tick) begin
            pwm_phase_ff <= pwm_phase_ff + 10'h001;
         end
         pwm_level_ff <= pwm_pin;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         instr_div_ff <= 2'h0;
         ext_sync1_ff <= 1'b0;
         ext_sync2_ff <= 1'b0;
         ext_prev_ff <= 1'b0;
      end else begin
         instr_div_ff <= instr_div_ff + 2'h1;
         ext_sync1_ff <= external_count_pin_in;
         ext_sync2_ff <= ext_sync1_ff;
         ext_prev_ff <= ext_sync2_ff;
      end
   end

   // pin mux registered so outputs come straight from flops
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         pin_ff <= 1'b0;
         pin_oe_ff <= 1'b0;
      end else if (ctrl_one_ff.pin_en) begin
         pin_ff <= pwm_level_ff;
         pin_oe_ff <= 1'b1;
      end else begin
         pin_ff <= gpio_out_in;
         pin_oe_ff <= gpio_oe_in;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         rdata_ff <= 32'h0000_0000;
         ready_ff <= 1'b0;
         slverr_ff <= 1'b0;
      end else begin
         ready_ff <= setup;
         slverr_ff <= setup & ~mapped;
         if (rd_en) begin
            rdata_ff <= {24'h00_0000, rbyte};
         end
      end
   end

   assign prdata_out = rdata_ff;
   assign pready_out = ready_ff;
   assign pslverr_out = slverr_ff;
   assign pwm_port_pin_out = pin_ff;
   assign pwm_port_pin_oe_out = pin_oe_ff;
   assign underflow_event_out = event_ff;
endmodule
`default_nettype wire

/* File: test/dcpwm_asserts.sv */
// dcpwm_asserts: port checks for dcpwm_timer, bound into it.
// assumes control one changes only through apb writes.
`default_nettype none
module dcpwm_asserts (
   // clock and reset
   input wire logic mclk_in,
   input wire logic rstn_in,
   // apb
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out,
   input wire logic pslverr_out,
   // pins and event
   input wire logic gpio_out_in,
   input wire logic gpio_oe_in,
   input wire logic pwm_port_pin_out,
   input wire logic pwm_port_pin_oe_out,
   input wire logic underflow_event_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);
   logic [7:0] ctl_ff;
   logic [3:0] idle_ff;
   logic done_ff;
   wire logic setup = psel_in && !penable_in;
   wire logic wr_acc = psel_in && penable_in && pready_out && pwrite_in;
   wire logic mapped = paddr_in inside {dcpwm_pkg::ADDR_COUNT_LOW, dcpwm_pkg::ADDR_CTRL_ONE,
      dcpwm_pkg::ADDR_CTRL_TWO, dcpwm_pkg::ADDR_DUTY, dcpwm_pkg::ADDR_PRESC_CNT,
      dcpwm_pkg::ADDR_HIGH_BITS, dcpwm_pkg::ADDR_STATUS};
   wire logic pen = ctl_ff[dcpwm_pkg::POS_PIN_EN];
   wire logic os = ctl_ff[dcpwm_pkg::POS_ONE_SHOT];
   // shadow of control one, the checker sees only ports
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         ctl_ff <= 8'h00;
      end else if (wr_acc && paddr_in == dcpwm_pkg::ADDR_CTRL_ONE) begin
         ctl_ff <= pwdata_in[7:0];
      end
   end
   // slack of 8 cycles: a tick may still sit in the pipeline
   always_ff @(posedge mclk_in) begin
      if (!rstn_in || ctl_ff[dcpwm_pkg::POS_RUN]) begin
         idle_ff <= 4'h0;
      end else if (idle_ff != 4'h8) begin
         idle_ff <= idle_ff + 4'h1;
      end
   end
   always_ff @(posedge mclk_in) begin
      if (!rstn_in || wr_acc) begin
         done_ff <= 1'b0;
      end else if (underflow_event_out && os) begin
         done_ff <= 1'b1;
      end
   end
   chk_ready_next: assert property (setup |=> pready_out)
      else $error("pready missing after setup");
   chk_ready_only: assert property (pready_out |-> penable_in && $past(setup))
      else $error("pready outside access");
   chk_read_upper: assert property (pready_out && !pwrite_in |-> prdata_out[31:8] == 24'h0)
      else $error("read data upper bits set");
   chk_unmap_err: assert property (setup && !mapped && !pwrite_in
      |=> pslverr_out && prdata_out == 32'h0) else $error("unmapped read not refused");
   chk_map_ok: assert property (setup && mapped |=> !pslverr_out)
      else $error("mapped access refused");
   chk_gpio_pass: assert property ($past(rstn_in) && !pen && !$past(pen)
      && $stable(gpio_out_in) && $stable(gpio_oe_in) |-> pwm_port_pin_out == gpio_out_in
      && pwm_port_pin_oe_out == gpio_oe_in) else $error("pin not following gpio");
   chk_pin_drive: assert property (pen && $past(pen) && $past(rstn_in) |-> pwm_port_pin_oe_out)
      else $error("pwm pin not driven");
   chk_idle_quiet: assert property (idle_ff == 4'h8 |-> !underflow_event_out)
      else $error("event while stopped");
   chk_event_once: assert property (underflow_event_out |=> !underflow_event_out [*3])
      else $error("event longer than a pulse");
   chk_shot_stops: assert property (done_ff && os |-> !underflow_event_out)
      else $error("second event in one-shot");
   cov_unmapped: cover property (setup && !mapped);
   cov_shot: cover property (done_ff && os);
   cov_pwm: cover property (pen && pwm_port_pin_oe_out);
endmodule
bind dcpwm_timer dcpwm_asserts chk_u (.mclk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in,
   .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .gpio_out_in, .gpio_oe_in,
   .pwm_port_pin_out, .pwm_port_pin_oe_out, .underflow_event_out);
`default_nettype wire

/* File: test/dcpwm_pin_model.sv */
// dcpwm_pin_model: outside count source on the external pin.
// assumes a two-flop synchroniser, so each level is held 9 cycles.
`default_nettype none
module dcpwm_pin_model (
   // clock
   input wire logic mclk_in,
   // pin
   output logic external_count_pin_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial external_count_pin_out = 1'b0;
   // one clean edge per call
   task automatic set_level(input logic v);
      @(posedge mclk_in);
      external_count_pin_out <= v;
      repeat (8) @(posedge mclk_in);
   endtask
   // pin idles low between pulses
   task automatic pulses(input int n);
      repeat (n) begin
         set_level(1'b1);
         set_level(1'b0);
      end
   endtask
endmodule
`default_nettype wire

/* File: test/dcpwm_timer_test.sv */
// dcpwm_timer_test: checks dcpwm_timer against an integer model.
// assumes the pin model is the only count source besides mclk/4.
`default_nettype none
module dcpwm_timer_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic gpio_out = 1'b0;
   logic gpio_oe = 1'b0;
   wire logic ext_pin;
   logic [31:0] prdata, rd;
   logic pready, pslverr, pin, pin_oe, ev, er;
   int bad_count = 0;
   int compares = 0;
   int ev_seen = 0;
   int seed = 40505;
   int mdl_cnt, mdl_rld, mdl_ev, mdl_rl, mdl_os, mdl_done, n;
   dcpwm_timer dut_u (.mclk_in, .rstn_in, .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .external_count_pin_in(ext_pin),
      .gpio_out_in(gpio_out), .gpio_oe_in(gpio_oe), .pwm_port_pin_out(pin),
      .pwm_port_pin_oe_out(pin_oe), .underflow_event_out(ev));
   dcpwm_pin_model pin_u (.mclk_in, .external_count_pin_out(ext_pin));
   initial begin
      forever #4 mclk_in = ~mclk_in;
   end
   always @(posedge mclk_in) if (ev === 1'b1) ev_seen++;
   task automatic tally_and_finish();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge mclk_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge mclk_in);
      penable <= 1'b1;
      do begin
         @(posedge mclk_in);
         k++;
      end while (pready !== 1'b1 && k < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         bad_count++;
         tally_and_finish();
      end
   endtask
   task automatic rdc(input logic [11:0] a, input int exp);
      apb(1'b0, a, 8'h00);
      cmp(rd, 32'(exp));
   endtask
   task automatic load(input int v);
      apb(1'b1, dcpwm_pkg::ADDR_HIGH_BITS, 8'((v >> 2) & 'hc0));
      apb(1'b1, dcpwm_pkg::ADDR_COUNT_LOW, v[7:0]);
      mdl_cnt = v;
      mdl_rld = v;
      mdl_done = 0;
   endtask
   task automatic tick(input int t);
      repeat (t) begin
         if (mdl_cnt != 0) mdl_cnt--;
         else if (mdl_os == 0) begin
            mdl_ev++;
            mdl_cnt = (mdl_rl != 0) ? mdl_rld : 'h3ff;
         end else if (mdl_done == 0) begin
            mdl_ev++;
            mdl_done = 1;
         end
      end
   endtask
   task automatic wait_ev();
      n = 0;
      do begin
         @(posedge mclk_in);
         n++;
      end while (ev !== 1'b1 && n < 200);
      if (n >= 200) begin
         bad_count++;
         tally_and_finish();
      end
   endtask
   initial begin
      repeat (8) @(posedge mclk_in);
      rstn_in <= 1'b1;
      apb(1'b1, dcpwm_pkg::ADDR_PRESC_CNT, 8'h12);
      rdc(dcpwm_pkg::ADDR_CTRL_ONE, 'h00);
      rdc(dcpwm_pkg::ADDR_CTRL_TWO, 'h3f);
      rdc(dcpwm_pkg::ADDR_PRESC_CNT, 'hff);
      rdc(12'h03c, 0);
      cmp(er, 1'b1);
      load('h205);
      rdc(dcpwm_pkg::ADDR_COUNT_LOW, 'h05);
      pin_u.pulses(3);
      rdc(dcpwm_pkg::ADDR_COUNT_LOW, 'h05);
      $display("test registers done");
      for (int m = 0; m < 4; m++) begin
         mdl_rl = m % 2;
         mdl_os = m / 2;
         load(2);
         mdl_ev = ev_seen;
         apb(1'b1, dcpwm_pkg::ADDR_CTRL_ONE, 8'(1 + m * 2));
         pin_u.pulses(4);
         tick(4);
         rdc(dcpwm_pkg::ADDR_COUNT_LOW, mdl_cnt & 'hff);
         cmp(ev_seen, mdl_ev);
         apb(1'b1, dcpwm_pkg::ADDR_CTRL_ONE, 8'h00);
      end
      $display("test modes done");
      mdl_os = 0;
      for (int e = 0; e < 2; e++) begin
         apb(1'b1, dcpwm_pkg::ADDR_CTRL_TWO, 8'('h2f | e * 16));
         load('h10);
         apb(1'b1, dcpwm_pkg::ADDR_CTRL_ONE, 8'h01);
         for (int l = 1; l >= 0; l--) begin
            pin_u.set_level(l[0]);
            if (l != e) tick(1);
            rdc(dcpwm_pkg::ADDR_COUNT_LOW, mdl_cnt);
         end
      end
      $display("test edges done");
      for (int r = 0; r < 4; r++) begin
         apb(1'b1, dcpwm_pkg::ADDR_CTRL_TWO, 8'('h28 | r));
         apb(1'b1, dcpwm_pkg::ADDR_CTRL_TWO, 8'('h20 | r));
         load('h40);
         pin_u.pulses(4 << r);
         tick(2);
         rdc(dcpwm_pkg::ADDR_COUNT_LOW, mdl_cnt);
      end
      $display("test prescaler done");
      apb(1'b1, dcpwm_pkg::ADDR_CTRL_TWO, 8'h08);
      load(3);
      apb(1'b1, dcpwm_pkg::ADDR_CTRL_ONE, 8'h03);
      wait_ev();
      wait_ev();
      cmp(n, 16);
      $display("test instruction clock done");
      for (int i = 0; i < 4; i++) begin
         gpio_out <= 1'($random(seed));
         gpio_oe <= 1'($random(seed));
         repeat (3) @(posedge mclk_in);
         cmp({pin_oe, pin}, {gpio_oe, gpio_out});
      end
      // duty above the period keeps the output active, duty zero never
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, dcpwm_pkg::ADDR_HIGH_BITS, 8'(k % 2 * 12));
         apb(1'b1, dcpwm_pkg::ADDR_DUTY, 8'(k % 2 * 255));
         apb(1'b1, dcpwm_pkg::ADDR_CTRL_ONE, 8'('h83 | k / 2 * 64));
         repeat (2) begin
            repeat (9) @(posedge mclk_in);
            cmp({pin_oe, pin}, {1'b1, 1'(k % 2 ^ k / 2)});
         end
      end
      $display("test pwm done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
